// ==== rtl/reg_selftest.sv ====
`timescale 1ns/1ns
`include "regtest_regs.svh"
// ----------------------------------------
// stack pointer and code bank self-test
// ----------------------------------------
module reg_selftest #(
   parameter int SP_W = 16,
   parameter int CB_W = 8
) (
   input  wire logic                 ref_clk,     // 25 MHz clock
   input  wire logic                 reset,       // sync reset, high
   input  wire logic                 start,       // one-cycle start pulse
   input  wire regtest_pkg::target_t target,      // register to test
   output logic                      busy,        // test in progress
   output logic                      done,        // one-cycle done pulse
   output logic                      result,      // 0 pass, 1 fail
   output logic [SP_W-1:0]           sp_value,    // stack pointer contents
   output logic [CB_W-1:0]           cb_value     // code bank contents
);
   import regtest_pkg::*;

   // ----------------------------------------
   // elaboration check
   // ----------------------------------------
   if (SP_W != 16 || CB_W != 8) begin : g_bad_width
      $error("reg_selftest supports only 16-bit sp and 8-bit bank");
   end

   // ----------------------------------------
   // declarations
   // ----------------------------------------
   state_t          state_r;      // sequencer state
   state_t          state_nxt;    // next state
   target_t         tgt_r;        // latched target
   target_t         tgt_nxt;      // next target
   logic [SP_W-1:0] save_r;       // saved original value
   logic [SP_W-1:0] save_nxt;     // next saved value
   logic            fail_r;       // any compare failed
   logic            fail_nxt;     // next fail flag
   logic            busy_r;       // busy output register
   logic            busy_nxt;     // next busy
   logic            done_r;       // done output register
   logic            done_nxt;     // next done
   logic            result_r;     // result output register
   logic            result_nxt;   // next result
   logic            sp_we;        // stack pointer write strobe
   logic            cb_we;        // code bank write strobe
   logic [SP_W-1:0] wdata;        // write data to registers
   logic [SP_W-1:0] sp_rdata;     // stack pointer read-back
   logic [CB_W-1:0] cb_rdata;     // code bank read-back

   // ----------------------------------------
   // helper functions
   // ----------------------------------------
   // pattern written in pass one or two
   function automatic logic [SP_W-1:0] pattern(input target_t t, input logic second);
      logic [SP_W-1:0] p;
      p = '0;
      if (t == TGT_STACK) begin
         p = second ? `SP_PAT2 : `SP_PAT1;
      end else begin
         p = {8'h00, (second ? `CB_PAT2 : `CB_PAT1)};
      end
      return p;
   endfunction

   // true when read-back differs from expectation
   function automatic logic mismatch(input target_t t, input logic second,
                                     input logic [SP_W-1:0] sp, input logic [CB_W-1:0] cb);
      logic m;
      m = 1'b0;
      if (t == TGT_STACK) begin
         m = sp != (second ? `SP_EXP2 : `SP_EXP1);
      end else begin
         // only low nibble is meaningful; upper bits read zero
         m = (cb & `CB_LOW_MASK) != ((second ? `CB_PAT2 : `CB_PAT1) & `CB_LOW_MASK);
      end
      return m;
   endfunction

   // ----------------------------------------
   // register under test
   // ----------------------------------------
   cpu_regs #(
      .SP_W (SP_W),
      .CB_W (CB_W)
   ) u_regs (
      .ref_clk  (ref_clk),
      .reset    (reset),
      .sp_we    (sp_we),
      .cb_we    (cb_we),
      .wdata    (wdata),
      .sp_rdata (sp_rdata),
      .cb_rdata (cb_rdata)
   );

   // ----------------------------------------
   // write strobes to the register model
   // ----------------------------------------
   // decoded from current state; read data returns one cycle later
   always_comb begin
      sp_we = 1'b0;
      cb_we = 1'b0;
      wdata = '0;
      unique case (state_r)
         ST_WR1, ST_WR2: begin
            // apply test pattern
            wdata = pattern(tgt_r, state_r == ST_WR2);
            sp_we = (tgt_r == TGT_STACK);
            cb_we = (tgt_r == TGT_BANK);
         end
         ST_REST: begin
            // put back original content
            wdata = save_r;
            sp_we = (tgt_r == TGT_STACK);
            cb_we = (tgt_r == TGT_BANK);
         end
         ST_IDLE, ST_SAVE, ST_CHK1, ST_CHK2, ST_DONE: begin
            wdata = '0;
         end
      endcase
   end

   // ----------------------------------------
   // sequencer next state
   // ----------------------------------------
   // caller keeps interrupts blocked from start to done
   always_comb begin
      state_nxt  = state_r;
      tgt_nxt    = tgt_r;
      save_nxt   = save_r;
      fail_nxt   = fail_r;
      busy_nxt   = busy_r;
      done_nxt   = 1'b0;
      result_nxt = result_r;
      unique case (state_r)
         ST_IDLE: begin
            // starts ignored while busy; only taken here
            if (start) begin
               tgt_nxt   = target;
               fail_nxt  = 1'b0;
               busy_nxt  = 1'b1;
               state_nxt = ST_SAVE;
            end
         end
         ST_SAVE: begin
            // capture original before first write
            save_nxt  = (tgt_r == TGT_STACK) ? sp_rdata : {8'h00, cb_rdata};
            state_nxt = ST_WR1;
         end
         ST_WR1: begin
            state_nxt = ST_CHK1;
         end
         ST_CHK1: begin
            // first read-back compare
            if (mismatch(tgt_r, 1'b0, sp_rdata, cb_rdata)) begin
               fail_nxt = 1'b1;
            end
            state_nxt = ST_WR2;
         end
         ST_WR2: begin
            state_nxt = ST_CHK2;
         end
         ST_CHK2: begin
            // second read-back compare
            if (mismatch(tgt_r, 1'b1, sp_rdata, cb_rdata)) begin
               fail_nxt = 1'b1;
            end
            state_nxt = ST_REST;
         end
         ST_REST: begin
            // restore write issued this cycle
            state_nxt = ST_DONE;
         end
         ST_DONE: begin
            // restore is visible now; publish result with done
            done_nxt   = 1'b1;
            result_nxt = fail_r ? `RES_FAIL : `RES_PASS;
            busy_nxt   = 1'b0;
            state_nxt  = ST_IDLE;
         end
      endcase
   end

   // ----------------------------------------
   // sequencer registers
   // ----------------------------------------
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         state_r  <= ST_IDLE;
         tgt_r    <= TGT_STACK;
         save_r   <= '0;
         fail_r   <= 1'b0;
         busy_r   <= 1'b0;
         done_r   <= 1'b0;
         result_r <= `RES_PASS;
      end else begin
         state_r  <= state_nxt;
         tgt_r    <= tgt_nxt;
         save_r   <= save_nxt;
         fail_r   <= fail_nxt;
         busy_r   <= busy_nxt;
         done_r   <= done_nxt;
         result_r <= result_nxt;
      end
   end

   // ----------------------------------------
   // outputs, all from flip-flops
   // ----------------------------------------
   // failure handler is invoked by the caller on result 1
   assign busy     = busy_r;
   assign done     = done_r;
   assign result   = result_r;
   assign sp_value = sp_rdata;
   assign cb_value = cb_rdata;
endmodule

// ==== rtl/regtest_regs.svh ====
// Operation
// - stack pointer tested as one 16-bit quantity
// - first stack pointer write is 5555h
// - first stack read must equal 5554h
// - second stack pointer write is AAAAh
// - second stack read must equal AAAAh
// - code bank register tested as 8 bits
// - code bank write 05h, read must match
// - code bank write 0Ah, read must match
// - code bank compares only low four bits
// - save register first, restore at finish
// - result one when any compare fails
`ifndef REGTEST_REGS_SVH
`define REGTEST_REGS_SVH
// ----------------------------------------
// test patterns and expected read values
// ----------------------------------------
`define SP_PAT1      16'h5555
`define SP_EXP1      16'h5554
`define SP_PAT2      16'hAAAA
`define SP_EXP2      16'hAAAA
`define CB_PAT1      8'h05
`define CB_PAT2      8'h0A
`define CB_LOW_MASK  8'h0F
`define SP_RESET     16'h0000
`define CB_RESET     8'h00
`define RES_PASS     1'b0
`define RES_FAIL     1'b1
`endif

// ==== rtl/regtest_pkg.sv ====
package regtest_pkg;
   // which register a test run targets
   typedef enum logic [0:0] {
      TGT_STACK = 1'b0,
      TGT_BANK  = 1'b1
   } target_t;
   // sequencer states
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_SAVE  = 3'b001,
      ST_WR1   = 3'b010,
      ST_CHK1  = 3'b011,
      ST_WR2   = 3'b100,
      ST_CHK2  = 3'b101,
      ST_REST  = 3'b110,
      ST_DONE  = 3'b111
   } state_t;
endpackage

// ==== rtl/cpu_regs.sv ====
`timescale 1ns/1ns
`include "regtest_regs.svh"
// ----------------------------------------
// processor register model under test
// ----------------------------------------
module cpu_regs #(
   parameter int SP_W = 16,
   parameter int CB_W = 8
) (
   input  wire logic            ref_clk,   // system clock
   input  wire logic            reset,     // sync reset, high
   input  wire logic            sp_we,     // stack pointer write
   input  wire logic            cb_we,     // code bank write
   input  wire logic [SP_W-1:0] wdata,     // write data
   output logic      [SP_W-1:0] sp_rdata,  // stack pointer read, registered
   output logic      [CB_W-1:0] cb_rdata   // code bank read, registered
);
   logic [SP_W-1:0] stack_pointer_reg_r;   // stack pointer storage
   logic [SP_W-1:0] stack_pointer_reg_nxt; // next value
   logic [CB_W-1:0] code_bank_r;           // code bank storage
   logic [CB_W-1:0] code_bank_nxt;         // next value
   // next-state: lowest sp bit and top four bank bits are hard zero
   always_comb begin
      stack_pointer_reg_nxt = stack_pointer_reg_r;
      code_bank_nxt         = code_bank_r;
      if (sp_we) begin
         stack_pointer_reg_nxt = {wdata[SP_W-1:1], 1'b0};
      end
      if (cb_we) begin
         code_bank_nxt = wdata[CB_W-1:0] & `CB_LOW_MASK;
      end
   end
   // storage and registered read port
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         stack_pointer_reg_r <= `SP_RESET;
         code_bank_r         <= `CB_RESET;
         sp_rdata            <= `SP_RESET;
         cb_rdata            <= `CB_RESET;
      end else begin
         stack_pointer_reg_r <= stack_pointer_reg_nxt;
         code_bank_r         <= code_bank_nxt;
         sp_rdata            <= stack_pointer_reg_nxt;
         cb_rdata            <= code_bank_nxt;
      end
   end
endmodule

// ==== verif/reg_selftest_assertions.sv ====
`timescale 1ns/1ns
// ----------------------------------------
// port checker of the register self-test
// ----------------------------------------
module reg_selftest_assertions
   import regtest_pkg::*;
#(
   parameter int SP_W = 16,  // stack width
   parameter int CB_W = 8    // bank width
) (
   input wire logic                 ref_clk,   // clock
   input wire logic                 reset,     // sync reset
   input wire logic                 start,     // start pulse
   input wire regtest_pkg::target_t target,    // register chosen
   input wire logic                 busy,      // test running
   input wire logic                 done,      // done pulse
   input wire logic                 result,    // 0 pass
   input wire logic [SP_W-1:0]      sp_value,  // stack contents
   input wire logic [CB_W-1:0]      cb_value   // bank contents
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (reset);
   logic take;  // a start that is accepted
   assign take = start && !busy;
   // busy for seven cycles from the edge after the take, then done alone
   a_busy_then_done: assert property (take |-> ##1 busy [*7] ##1 (done && !busy))
      else $error("busy or done timing wrong");
   a_done_one_cycle: assert property (done |=> !done)
      else $error("done longer than one cycle");
   a_pass_result: assert property (done |-> result == 1'b0)
      else $error("healthy run reported failure");
   a_stack_first_read: assert property (take && target == TGT_STACK |-> ##3 sp_value == 16'h5554)
      else $error("first stack pattern wrong");
   a_stack_second_read: assert property (take && target == TGT_STACK |-> ##5 sp_value == 16'hAAAA)
      else $error("second stack pattern wrong");
   a_bank_first_read: assert property (take && target == TGT_BANK |-> ##3 cb_value == 8'h05)
      else $error("first bank pattern wrong");
   a_bank_second_read: assert property (take && target == TGT_BANK |-> ##5 cb_value == 8'h0A)
      else $error("second bank pattern wrong");
   // both registers hold their old contents once the restore has landed
   a_restore_both: assert property (take |-> ##7 (sp_value == $past(sp_value, 7) && cb_value == $past(cb_value, 7)))
      else $error("register not restored");
   a_fixed_bits: assert property (sp_value[0] == 1'b0 && cb_value[7:4] == 4'h0)
      else $error("fixed zero bits set");
   c_stack_run: cover property (take && target == TGT_STACK);
   c_bank_run: cover property (take && target == TGT_BANK);
   c_back_to_back: cover property (done && start);
endmodule
bind reg_selftest reg_selftest_assertions #(.SP_W(SP_W), .CB_W(CB_W)) chk (.ref_clk(ref_clk), .reset(reset),
   .start(start), .target(target), .busy(busy), .done(done), .result(result), .sp_value(sp_value),
   .cb_value(cb_value));

// ==== verif/reg_selftest_test.sv ====
`timescale 1ns/1ns
`define check(got, exp) begin checked++; if ((got) !== (exp)) begin err_count++; \
   $display("ERROR %0t: got %0h expected %0h", $time, got, exp); end end
// ----------------------------------------
// self-checking bench of the register self-test
// ----------------------------------------
module reg_selftest_test;
   import regtest_pkg::*;
   logic        ref_clk = 1'b0;   // 25 MHz clock
   logic        reset;            // sync reset
   logic        start;            // start pulse
   target_t     target;           // register chosen
   logic        busy;             // test running
   logic        done;             // done pulse
   logic        result;           // 0 pass
   logic [15:0] sp_value;         // stack contents
   logic [7:0]  cb_value;         // bank contents
   int          err_count = 0;    // mismatches
   int          checked = 0;      // comparisons
   int          cycles = 0;       // timeout counter
   always #20 ref_clk = ~ref_clk;
   reg_selftest #(.SP_W(16), .CB_W(8)) dut (.ref_clk(ref_clk), .reset(reset), .start(start), .target(target),
      .busy(busy), .done(done), .result(result), .sp_value(sp_value), .cb_value(cb_value));
   // cut a hang short
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 2000) begin
         err_count++;
         complete_run();
      end
   end
   // print counts and verdict, then stop
   task complete_run;
      $display("checked %0d errors %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // one run; pre: start already raised, chain: raise next start with done, poke: start while busy
   // caller keeps interrupts blocked from start to done: nothing else disturbs the run
   task run_test(input target_t tg, input bit pre, input bit chain, input bit poke);
      if (!pre) begin
         @(posedge ref_clk);
         start  <= 1'b1;
         target <= tg;
      end
      for (int n = 0; n <= 7; n++) begin
         @(posedge ref_clk);
         start  <= (n == 2 && poke) || (n == 7 && chain);
         target <= ((n == 2 && poke) || (n == 7 && chain)) ? target_t'(~tg) : tg;
         @(negedge ref_clk);
         if (n <= 6) begin
            `check(busy, 1'b1)
         end
         `check(done, (n == 7))
         if (n == 2 || n == 4) begin
            `check(sp_value, tg == TGT_BANK ? 16'h0000 : (n == 2 ? 16'h5554 : 16'hAAAA))
            `check(cb_value, tg == TGT_STACK ? 8'h00 : (n == 2 ? 8'h05 : 8'h0A))
         end
         if (n == 7) begin
            `check(busy, 1'b0)
            `check(result, 1'b0)
            `check({sp_value, cb_value}, 24'h000000)
         end
      end
   endtask
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      reset  = 1'b1;
      start  = 1'b0;
      target = TGT_STACK;
      repeat (3) @(posedge ref_clk);
      reset <= 1'b0;
      @(negedge ref_clk);
      `check({busy, done, result, sp_value, cb_value}, 27'h0000000)
      run_test(TGT_STACK, 1'b0, 1'b0, 1'b0);
      run_test(TGT_BANK, 1'b0, 1'b0, 1'b1);
      run_test(TGT_STACK, 1'b0, 1'b1, 1'b0);
      run_test(TGT_BANK, 1'b1, 1'b0, 1'b0);
      // reset in mid-run aborts the test
      @(posedge ref_clk);
      start <= 1'b1;
      @(posedge ref_clk);
      start <= 1'b0;
      repeat (4) @(posedge ref_clk);
      reset <= 1'b1;
      @(posedge ref_clk);
      reset <= 1'b0;
      @(negedge ref_clk);
      `check({busy, done, sp_value, cb_value}, 26'h0000000)
      run_test(TGT_STACK, 1'b0, 1'b0, 1'b0);
      complete_run();
   end
endmodule
